// File: core/wrc_map.svh
// Constants for the watchdog, system reset and run-time clock block
`ifndef WRC_MAP_SVH
`define WRC_MAP_SVH
`define WRC_CLK_HZ 50000000
`define WRC_MS_PER_S 1000
`define WRC_CYC_PER_MS (`WRC_CLK_HZ / `WRC_MS_PER_S)
`define WRC_MS_PER_DAY 32'h0526_5c00
`define WRC_DLY_SEL_W 5
`define WRC_DLY_SEL_MAX 5'h10
`define WRC_WAIT_SEL_W 4
`define WRC_WAIT_BASE_MS 32'h0000_0064
`define WRC_PULSE_MIN_MS 16'h0001
`define WRC_PULSE_MAX_MS 16'h7e00
`define WRC_TIME_W 32
`endif

// File: core/wrc_ms_tick.sv
// Millisecond tick generator
`timescale 1ns/1ns
`include "wrc_map.svh"
module wrc_ms_tick #(
   parameter int CYC_PER_MS = `WRC_CYC_PER_MS
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   output logic o_tick
);
   if (CYC_PER_MS < 2) begin : g_bad_cyc_per_ms
      $error("CYC_PER_MS must be at least 2");
   end
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   always_comb begin
      tick_next = 1'b0;
      cnt_next = cnt_reg + 32'h1;
      if (cnt_reg == 32'(CYC_PER_MS - 1)) begin
         cnt_next = 32'h0;
         tick_next = 1'b1;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign o_tick = tick_reg;
endmodule : wrc_ms_tick

// File: core/wrc_pkg.sv
// Types shared by the watchdog, system reset and run-time clock block
package wrc_pkg;
   typedef enum logic [1:0] {
      WRC_RST_HOLD,
      WRC_RST_DELAY,
      WRC_RST_PULSE,
      WRC_RST_RUN
   } wrc_rst_state_type;
   typedef enum logic [1:0] {
      WRC_WD_OFF,
      WRC_WD_WAIT,
      WRC_WD_TIMING,
      WRC_WD_EXPIRED
   } wrc_wd_state_type;
endpackage : wrc_pkg

// File: core/wrc_top.sv
// Watchdog, system reset generator and run-time clock
`timescale 1ns/1ns
`include "wrc_map.svh"
module wrc_top #(
   parameter int PULSE_W = 16,
   parameter int TRACK_MAX_MS = 100
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_power_good,
   input wire logic i_pulse_mode,
   input wire logic [`WRC_DLY_SEL_W-1:0] i_delay_sel,
   input wire logic [PULSE_W-1:0] i_pulse_ms,
   input wire logic i_wd_enable,
   input wire logic i_wd_kick_pin_en,
   input wire logic i_watchdog_kick_input,
   input wire logic i_wd_clear_cmd,
   input wire logic i_wd_wait_en,
   input wire logic [`WRC_WAIT_SEL_W-1:0] i_wd_wait_sel,
   input wire logic [PULSE_W-1:0] i_wd_timeout_ms,
   input wire logic i_wd_expiry_pin_en,
   input wire logic i_wd_reset_on_expiry,
   input wire logic i_wd_track_release,
   input wire logic i_general_input_pin,
   input wire logic i_brownout_en,
   input wire logic i_boot_done,
   input wire logic i_rtc_load,
   input wire logic [`WRC_TIME_W-1:0] i_rtc_load_ms,
   input wire logic [`WRC_TIME_W-1:0] i_rtc_load_days,
   input wire logic [`WRC_TIME_W-1:0] i_rtc_restore_ms,
   input wire logic [`WRC_TIME_W-1:0] i_rtc_restore_days,
   input wire logic i_store_cmd,
   input wire logic i_power_down,
   input wire logic i_fault_event,
   output logic o_sys_reset_n,
   output logic o_watchdog_expiry_output,
   output logic o_wd_expired,
   output logic [`WRC_TIME_W-1:0] o_rtc_ms,
   output logic [`WRC_TIME_W-1:0] o_rtc_days,
   output logic o_nvm_save,
   output logic [`WRC_TIME_W-1:0] o_nvm_ms,
   output logic [`WRC_TIME_W-1:0] o_nvm_days,
   output logic o_fault_stamp_valid,
   output logic [`WRC_TIME_W-1:0] o_fault_stamp_ms,
   output logic [`WRC_TIME_W-1:0] o_fault_stamp_days
);
   if (PULSE_W < 15 || PULSE_W > 31) begin : g_bad_pulse_w
      $error("PULSE_W must hold 32256 ms and stay below 32 bits");
   end
   // ----------------------------------------
   // Pin synchronisers and ms tick
   // ----------------------------------------
   logic [1:0] pg_sync_reg;
   logic [1:0] kick_sync_reg;
   logic [1:0] gpi_sync_reg;
   logic kick_last_reg;
   logic tick;
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pg_sync_reg <= 2'h0;
         kick_sync_reg <= 2'h0;
         gpi_sync_reg <= 2'h0;
         kick_last_reg <= 1'b0;
      end else begin
         pg_sync_reg <= {pg_sync_reg[0], i_power_good};
         kick_sync_reg <= {kick_sync_reg[0], i_watchdog_kick_input};
         gpi_sync_reg <= {gpi_sync_reg[0], i_general_input_pin};
         kick_last_reg <= kick_sync_reg[1];
      end
   end
   wire logic pg = pg_sync_reg[1];
   wire logic general_input_pin = gpi_sync_reg[1];
   // Either edge of the kick pin counts; the pin path is optional
   wire logic kick = (i_wd_kick_pin_en && (kick_sync_reg[1] != kick_last_reg)) || i_wd_clear_cmd;
   wrc_ms_tick u_tick (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .o_tick(tick)
   );
   // Delay table: zero, then 2^(sel-1) ms, with sel capped at 16
   function automatic logic [`WRC_TIME_W-1:0] delay_ms(input logic [`WRC_DLY_SEL_W-1:0] sel);
      logic [`WRC_DLY_SEL_W-1:0] s;
      s = (sel > `WRC_DLY_SEL_MAX) ? `WRC_DLY_SEL_MAX : sel;
      delay_ms = (s == '0) ? '0 : (`WRC_TIME_W'(1) << (s - 1'b1));
   endfunction : delay_ms
   // Clamp a pulse or timeout width to its legal range
   function automatic logic [`WRC_TIME_W-1:0] clamp_ms(input logic [PULSE_W-1:0] v);
      logic [`WRC_TIME_W-1:0] w;
      w = `WRC_TIME_W'(v);
      if (w < `WRC_TIME_W'(`WRC_PULSE_MIN_MS)) w = `WRC_TIME_W'(`WRC_PULSE_MIN_MS);
      if (w > `WRC_TIME_W'(`WRC_PULSE_MAX_MS)) w = `WRC_TIME_W'(`WRC_PULSE_MAX_MS);
      clamp_ms = w;
   endfunction : clamp_ms
   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   wrc_pkg::wrc_wd_state_type wd_state_reg;
   wrc_pkg::wrc_wd_state_type wd_state_next;
   logic [`WRC_TIME_W-1:0] wd_cnt_reg;
   logic [`WRC_TIME_W-1:0] wd_cnt_next;
   logic wdo_reg;
   logic wdo_next;
   logic expired_reg;
   logic expired_next;
   logic wd_fire;
   always_comb begin
      wd_state_next = wd_state_reg;
      wd_cnt_next = wd_cnt_reg;
      wdo_next = wdo_reg;
      wd_fire = 1'b0;
      case (wd_state_reg)
         wrc_pkg::WRC_WD_OFF: begin
            wdo_next = 1'b0;
            wd_cnt_next = '0;
            if (i_wd_enable) begin
               wd_state_next = i_wd_wait_en ? wrc_pkg::WRC_WD_WAIT : wrc_pkg::WRC_WD_TIMING;
            end
         end
         wrc_pkg::WRC_WD_WAIT: begin
            // Initial wait: 0 or 100 ms doubling; a kick ends it early
            if (kick || i_wd_wait_sel == '0 ||
                wd_cnt_reg >= (`WRC_WAIT_BASE_MS << (i_wd_wait_sel - 1'b1))) begin
               wd_state_next = wrc_pkg::WRC_WD_TIMING;
               wd_cnt_next = '0;
            end else if (tick) begin
               wd_cnt_next = wd_cnt_reg + 1'b1;
            end
         end
         wrc_pkg::WRC_WD_TIMING: begin
            if (kick) begin
               wd_cnt_next = '0;
            end else if (wd_cnt_reg >= clamp_ms(i_wd_timeout_ms)) begin
               wd_state_next = wrc_pkg::WRC_WD_EXPIRED;
               wdo_next = i_wd_expiry_pin_en;
               wd_fire = 1'b1;
            end else if (tick) begin
               wd_cnt_next = wd_cnt_reg + 1'b1;
            end
         end
         wrc_pkg::WRC_WD_EXPIRED: begin
            if (kick) begin
               wd_state_next = wrc_pkg::WRC_WD_TIMING;
               wd_cnt_next = '0;
               wdo_next = 1'b0;
            end
         end
         default: wd_state_next = wrc_pkg::WRC_WD_OFF;
      endcase
      if (!i_wd_enable) begin
         wd_state_next = wrc_pkg::WRC_WD_OFF;
         wdo_next = 1'b0;
      end
      // Registered copy of the state decode keeps the status output glitch free
      expired_next = (wd_state_next == wrc_pkg::WRC_WD_EXPIRED);
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wd_state_reg <= wrc_pkg::WRC_WD_OFF;
         wd_cnt_reg <= '0;
         wdo_reg <= 1'b0;
         expired_reg <= 1'b0;
      end else begin
         wd_state_reg <= wd_state_next;
         wd_cnt_reg <= wd_cnt_next;
         wdo_reg <= wdo_next;
         expired_reg <= expired_next;
      end
   end
   // ----------------------------------------
   // System reset
   // ----------------------------------------
   wrc_pkg::wrc_rst_state_type rs_state_reg;
   wrc_pkg::wrc_rst_state_type rs_state_next;
   logic [`WRC_TIME_W-1:0] rs_cnt_reg;
   logic [`WRC_TIME_W-1:0] rs_cnt_next;
   logic rst_n_reg;
   logic rst_n_next;
   logic track_reg;
   logic track_next;
   // Watchdog expiry restarts the release sequence from RUN when configured
   wire logic wd_reset = wd_fire && i_wd_reset_on_expiry;
   always_comb begin
      rs_state_next = rs_state_reg;
      rs_cnt_next = rs_cnt_reg;
      rst_n_next = rst_n_reg;
      track_next = track_reg;
      case (rs_state_reg)
         wrc_pkg::WRC_RST_HOLD: begin
            rst_n_next = 1'b0;
            rs_cnt_next = '0;
            if (pg) begin
               rs_state_next = wrc_pkg::WRC_RST_DELAY;
            end
         end
         wrc_pkg::WRC_RST_DELAY: begin
            // Tracking release ends on the input pin, bounded by a time cap
            if (!pg && !i_pulse_mode) begin
               rs_state_next = wrc_pkg::WRC_RST_HOLD;
            end else if (track_reg ? (general_input_pin || rs_cnt_reg >= 32'(TRACK_MAX_MS))
                                   : (rs_cnt_reg >= delay_ms(i_delay_sel))) begin
               rs_cnt_next = '0;
               track_next = 1'b0;
               rst_n_next = i_pulse_mode ? 1'b0 : 1'b1;
               rs_state_next = i_pulse_mode ? wrc_pkg::WRC_RST_PULSE : wrc_pkg::WRC_RST_RUN;
            end else if (tick) begin
               rs_cnt_next = rs_cnt_reg + 1'b1;
            end
         end
         wrc_pkg::WRC_RST_PULSE: begin
            // Output stays asserted through the delay and the pulse; released once the pulse ends
            if (rs_cnt_reg >= clamp_ms(i_pulse_ms)) begin
               rst_n_next = 1'b1;
               rs_cnt_next = '0;
               rs_state_next = wrc_pkg::WRC_RST_RUN;
            end else if (tick) begin
               rs_cnt_next = rs_cnt_reg + 1'b1;
            end
         end
         wrc_pkg::WRC_RST_RUN: begin
            if (!pg && !i_pulse_mode) begin
               // Reassert after the common delay once power-good drops
               if (rs_cnt_reg >= delay_ms(i_delay_sel)) begin
                  rs_state_next = wrc_pkg::WRC_RST_HOLD;
                  rst_n_next = 1'b0;
               end else if (tick) begin
                  rs_cnt_next = rs_cnt_reg + 1'b1;
               end
            end else if (!pg) begin
               rs_state_next = wrc_pkg::WRC_RST_HOLD;
            end else begin
               rs_cnt_next = '0;
            end
         end
         default: rs_state_next = wrc_pkg::WRC_RST_HOLD;
      endcase
      if (wd_reset && rs_state_reg == wrc_pkg::WRC_RST_RUN) begin
         rst_n_next = 1'b0;
         rs_cnt_next = '0;
         track_next = i_wd_track_release;
         rs_state_next = wrc_pkg::WRC_RST_DELAY;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rs_state_reg <= wrc_pkg::WRC_RST_HOLD;
         rs_cnt_reg <= '0;
         rst_n_reg <= 1'b0;
         track_reg <= 1'b0;
      end else begin
         rs_state_reg <= rs_state_next;
         rs_cnt_reg <= rs_cnt_next;
         rst_n_reg <= rst_n_next;
         track_reg <= track_next;
      end
   end
   // ----------------------------------------
   // Run-time clock, save and fault stamp
   // ----------------------------------------
   logic [`WRC_TIME_W-1:0] ms_reg;
   logic [`WRC_TIME_W-1:0] ms_next;
   logic [`WRC_TIME_W-1:0] day_reg;
   logic [`WRC_TIME_W-1:0] day_next;
   logic init_reg;
   logic init_next;
   logic save_reg;
   logic save_next;
   logic [`WRC_TIME_W-1:0] nvm_ms_reg;
   logic [`WRC_TIME_W-1:0] nvm_day_reg;
   logic stamp_v_reg;
   logic [`WRC_TIME_W-1:0] stamp_ms_reg;
   logic [`WRC_TIME_W-1:0] stamp_day_reg;
   always_comb begin
      ms_next = ms_reg;
      day_next = day_reg;
      init_next = 1'b1;
      // Restored value is taken once after reset; it is not known during reset
      if (!init_reg) begin
         ms_next = i_brownout_en ? i_rtc_restore_ms : '0;
         day_next = i_brownout_en ? i_rtc_restore_days : '0;
      end else if (i_rtc_load) begin
         ms_next = i_rtc_load_ms;
         day_next = i_rtc_load_days;
      end else if (tick && (i_boot_done || !i_brownout_en)) begin
         if (ms_reg >= `WRC_MS_PER_DAY - 1) begin
            ms_next = '0;
            day_next = day_reg + 1'b1;
         end else begin
            ms_next = ms_reg + 1'b1;
         end
      end
      save_next = init_reg && (i_store_cmd || (i_power_down && i_brownout_en));
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ms_reg <= '0;
         day_reg <= '0;
         init_reg <= 1'b0;
         save_reg <= 1'b0;
         nvm_ms_reg <= '0;
         nvm_day_reg <= '0;
         stamp_v_reg <= 1'b0;
         stamp_ms_reg <= '0;
         stamp_day_reg <= '0;
      end else begin
         ms_reg <= ms_next;
         day_reg <= day_next;
         init_reg <= init_next;
         save_reg <= save_next;
         if (save_next) begin
            nvm_ms_reg <= ms_reg;
            nvm_day_reg <= day_reg;
         end
         stamp_v_reg <= i_fault_event;
         if (i_fault_event) begin
            stamp_ms_reg <= ms_reg;
            stamp_day_reg <= day_reg;
         end
      end
   end
   assign o_sys_reset_n = rst_n_reg;
   assign o_watchdog_expiry_output = wdo_reg;
   assign o_wd_expired = expired_reg;
   assign o_rtc_ms = ms_reg;
   assign o_rtc_days = day_reg;
   assign o_nvm_save = save_reg;
   assign o_nvm_ms = nvm_ms_reg;
   assign o_nvm_days = nvm_day_reg;
   assign o_fault_stamp_valid = stamp_v_reg;
   assign o_fault_stamp_ms = stamp_ms_reg;
   assign o_fault_stamp_days = stamp_day_reg;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_kick_expired;
      o_wd_expired && kick;
   endsequence
   AST_HOLD_NO_PG: assert property (rs_state_reg == wrc_pkg::WRC_RST_HOLD |=> !o_sys_reset_n)
      else $error("reset released while holding");
   AST_PULSE_LOW: assert property ($rose(rs_state_reg == wrc_pkg::WRC_RST_PULSE) |-> !o_sys_reset_n)
      else $error("pulse state without reset asserted");
   AST_RESTART: assert property (s_kick_expired |=> !o_wd_expired && wd_cnt_reg == '0)
      else $error("watchdog did not restart on kick");
   AST_KICK_CLR: assert property (wd_state_reg == wrc_pkg::WRC_WD_TIMING && kick && i_wd_enable
      |=> wd_cnt_reg == '0)
      else $error("kick did not clear counter");
   AST_WDO: assert property ($rose(o_watchdog_expiry_output) |-> o_wd_expired)
      else $error("expiry output without expiry");
   AST_TIMEOUT: assert property (wd_state_reg == wrc_pkg::WRC_WD_TIMING
      |-> wd_cnt_reg <= `WRC_TIME_W'(`WRC_PULSE_MAX_MS))
      else $error("watchdog count beyond maximum timeout");
   AST_MS_WRAP: assert property (ms_reg < `WRC_MS_PER_DAY || i_rtc_load || $past(i_rtc_load) || !init_reg)
      else $error("millisecond count passed one day");
   AST_STAMP: assert property (i_fault_event |=> o_fault_stamp_valid && o_fault_stamp_ms == $past(ms_reg))
      else $error("fault stamp mismatch");
   AST_RTC_LOAD: assert property (init_reg && i_rtc_load |=> o_rtc_ms == $past(i_rtc_load_ms))
      else $error("clock load not applied");
   AST_RTC_ZERO: assert property ($fell(i_rst) && !i_brownout_en |=> o_rtc_ms == '0 && o_rtc_days == '0)
      else $error("clock not zero after reset");
endmodule : wrc_top

// File: verif/wrc_host_model.sv
// Host processor model that services the watchdog by pin toggle or clear command
`timescale 1ns/1ns
module wrc_host_model (
   input wire logic i_mclk,
   input wire logic i_sys_reset_n,
   input wire logic i_kick,
   input wire logic i_clear,
   output logic o_kick_pin,
   output logic o_clear_cmd
);
   // ----------------------------------------
   // Kick generation
   // ----------------------------------------
   initial begin
      o_kick_pin = 1'b0;
      o_clear_cmd = 1'b0;
   end
   // A host held in reset cannot service the watchdog, so requests are dropped then
   always @(posedge i_mclk) begin
      if (i_kick && i_sys_reset_n) begin
         o_kick_pin <= ~o_kick_pin;
      end
      o_clear_cmd <= i_clear & i_sys_reset_n;
   end
endmodule : wrc_host_model

// File: verif/wrc_top_tb.sv
// Self-checking testbench for the watchdog, system reset and run-time clock block
`timescale 1ns/1ns
`include "wrc_map.svh"
module wrc_top_tb;
   logic i_mclk, i_rst, i_power_good, i_pulse_mode, i_wd_enable, i_wd_kick_pin_en;
   logic i_wd_wait_en, i_wd_expiry_pin_en, i_wd_reset_on_expiry, i_wd_track_release;
   logic i_general_input_pin, i_brownout_en, i_boot_done, i_rtc_load, i_store_cmd;
   logic i_power_down, i_fault_event, kick_req, clear_req, kick_pin, clear_cmd;
   logic [4:0] i_delay_sel;
   logic [3:0] i_wd_wait_sel;
   logic [15:0] i_pulse_ms, i_wd_timeout_ms;
   logic [31:0] i_rtc_load_ms, i_rtc_load_days, i_rtc_restore_ms, i_rtc_restore_days;
   logic o_sys_reset_n, o_watchdog_expiry_output, o_wd_expired, o_nvm_save, o_fault_stamp_valid;
   logic [31:0] o_rtc_ms, o_rtc_days, o_nvm_ms, o_nvm_days, o_fault_stamp_ms, o_fault_stamp_days;
   logic [31:0] ms, days;
   logic [63:0] exp;
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;
   int k;

   wrc_top u_dut (.i_mclk, .i_rst, .i_power_good, .i_pulse_mode, .i_delay_sel, .i_pulse_ms,
      .i_wd_enable, .i_wd_kick_pin_en, .i_watchdog_kick_input(kick_pin), .i_wd_clear_cmd(clear_cmd),
      .i_wd_wait_en, .i_wd_wait_sel, .i_wd_timeout_ms, .i_wd_expiry_pin_en, .i_wd_reset_on_expiry,
      .i_wd_track_release, .i_general_input_pin, .i_brownout_en, .i_boot_done, .i_rtc_load,
      .i_rtc_load_ms, .i_rtc_load_days, .i_rtc_restore_ms, .i_rtc_restore_days, .i_store_cmd,
      .i_power_down, .i_fault_event, .o_sys_reset_n, .o_watchdog_expiry_output, .o_wd_expired,
      .o_rtc_ms, .o_rtc_days, .o_nvm_save, .o_nvm_ms, .o_nvm_days, .o_fault_stamp_valid,
      .o_fault_stamp_ms, .o_fault_stamp_days);

   wrc_host_model u_host (.i_mclk(i_mclk), .i_sys_reset_n(o_sys_reset_n), .i_kick(kick_req),
      .i_clear(clear_req), .o_kick_pin(kick_pin), .o_clear_cmd(clear_cmd));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   // Ceiling covers one 50000-cycle ms tick for the wrap and expiry tests plus margin
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 90000) begin
         err_total++;
         conclude();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #2;
   endtask : cyc

   task automatic chk_bit(input logic got, input logic want);
      n_tests++;
      if (got !== want) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      n_tests++;
      if (got !== want) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk_word

   function automatic logic sig(input int w);
      case (w)
         0: return o_sys_reset_n;
         1: return o_wd_expired;
         2: return o_fault_stamp_valid;
         default: return o_nvm_save;
      endcase
   endfunction : sig

   // Bounded wait for a flag, then compare it
   task automatic wait_sig(input int w, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(w) !== v && n < lim) begin
         cyc(1);
         n++;
      end
      chk_bit(sig(w), v);
   endtask : wait_sig

   function automatic logic [63:0] next_ms(input logic [31:0] m, input logic [31:0] d);
      if (m + 32'h1 >= `WRC_MS_PER_DAY) begin
         return {d + 32'h1, 32'h0};
      end
      return {d, m + 32'h1};
   endfunction : next_ms

   task automatic do_reset(input logic bo);
      i_brownout_en = bo;
      i_rst = 1'b1;
      cyc(12);
      i_rst = 1'b0;
      cyc(3);
   endtask : do_reset

   task automatic load_rtc(input logic [31:0] m, input logic [31:0] d);
      i_rtc_load_ms = m;
      i_rtc_load_days = d;
      i_rtc_load = 1'b1;
      cyc(1);
      i_rtc_load = 1'b0;
      cyc(1);
   endtask : load_rtc

   task automatic conclude();
      $display("counts: compares=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {i_rst, i_power_good, i_pulse_mode, i_wd_wait_en, i_wd_reset_on_expiry} = 5'h10;
      {i_wd_track_release, i_power_down, i_rtc_load, i_store_cmd, i_fault_event} = 5'h00;
      {i_wd_enable, i_wd_kick_pin_en, i_wd_expiry_pin_en, i_brownout_en} = 4'he;
      {kick_req, clear_req, i_general_input_pin, i_boot_done} = 4'h0;
      {i_delay_sel, i_wd_wait_sel, i_pulse_ms} = 25'h0;
      i_wd_timeout_ms = 16'h0001;
      {i_rtc_load_ms, i_rtc_load_days, i_rtc_restore_ms, i_rtc_restore_days} = 128'h0;
      void'($urandom(8454));
      i_pulse_ms = 16'($urandom);
      i_wd_wait_sel = 4'($urandom);
      i_general_input_pin = 1'($urandom);
      i_boot_done = 1'($urandom);
      do_reset(1'b0);
      cyc(20);
      chk_bit(o_sys_reset_n, 1'b0);
      chk_word(o_rtc_ms, 32'h0);
      i_power_good = 1'b1;
      wait_sig(0, 1'b1, 10);
      i_power_good = 1'b0;
      wait_sig(0, 1'b0, 10);
      i_power_good = 1'b1;
      wait_sig(0, 1'b1, 10);
      $display("test reset_release done");
      for (int i = 0; i < 6; i++) begin
         ms = $urandom % `WRC_MS_PER_DAY;
         days = $urandom;
         load_rtc(ms, days);
         chk_word(o_rtc_ms, ms);
         chk_word(o_rtc_days, days);
         {i_fault_event, i_store_cmd} = i[0] ? 2'h2 : 2'h1;
         cyc(1);
         {i_fault_event, i_store_cmd} = 2'h0;
         if (i[0]) begin
            wait_sig(2, 1'b1, 4);
            chk_word(o_fault_stamp_ms, ms);
            chk_word(o_fault_stamp_days, days);
         end else begin
            wait_sig(3, 1'b1, 4);
            chk_word(o_nvm_ms, ms);
            chk_word(o_nvm_days, days);
         end
      end
      $display("test clock_load_stamp_save done");
      ms = `WRC_MS_PER_DAY - 32'h1;
      days = 32'hffff_fffe;
      load_rtc(ms, days);
      k = 0;
      while (o_rtc_ms === ms && k < 60000) begin
         cyc(1);
         k++;
      end
      exp = next_ms(ms, days);
      chk_word(o_rtc_ms, exp[31:0]);
      chk_word(o_rtc_days, exp[63:32]);
      $display("test day_wrap done");
      wait_sig(1, 1'b1, 60000);
      chk_bit(o_watchdog_expiry_output, 1'b1);
      chk_bit(o_sys_reset_n, 1'b1);
      // Pin disabled: the command alone must be able to restart the watchdog
      i_wd_kick_pin_en = 1'b0;
      kick_req = 1'b1;
      cyc(1);
      kick_req = 1'b0;
      cyc(10);
      chk_bit(o_wd_expired, 1'b1);
      clear_req = 1'b1;
      cyc(1);
      clear_req = 1'b0;
      wait_sig(1, 1'b0, 10);
      chk_bit(o_watchdog_expiry_output, 1'b0);
      $display("test watchdog_expiry done");
      i_boot_done = 1'b0;
      i_rtc_restore_ms = $urandom % `WRC_MS_PER_DAY;
      i_rtc_restore_days = $urandom;
      do_reset(1'b1);
      chk_word(o_rtc_ms, i_rtc_restore_ms);
      chk_word(o_rtc_days, i_rtc_restore_days);
      i_power_down = 1'b1;
      cyc(1);
      i_power_down = 1'b0;
      wait_sig(3, 1'b1, 4);
      chk_word(o_nvm_ms, i_rtc_restore_ms);
      chk_word(o_nvm_days, i_rtc_restore_days);
      // Pulse mode: with power-good up and zero delay, reset must still be low 20 cycles after the restart, inside the pulse
      i_pulse_mode = 1'b1;
      do_reset(1'b0);
      chk_word(o_rtc_ms, 32'h0);
      chk_word(o_rtc_days, 32'h0);
      cyc(20);
      chk_bit(o_sys_reset_n, 1'b0);
      $display("test brownout_restart done");
      conclude();
   end
endmodule : wrc_top_tb
